// *** src/fmc_controller.sv ***
// clock mode controller: source and reference switching, status, trim
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "fmc_map.svh"

module fmc_controller
    import fmc_pkg::*;
#(
    parameter int ALIVE_CYCLES = `FMC_ALIVE_CYCLES,
    parameter int OSC_INIT_CYCLES = `FMC_OSC_INIT_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire fmc_bus_req_type bus_req,
    output logic [7:0] rdata,
    input wire logic fll_clk_in,
    input wire logic int_ref_clk,
    input wire logic ext_ref_clk,
    input wire logic debug_mode_active,
    input wire logic stop_mode,
    output logic output_clock_en,
    output logic debug_link_clock_en,
    output logic internal_ref_output_en,
    output logic external_ref_output_en,
    output logic fll_enable,
    output logic dco_faster,
    output logic dco_slower,
    output logic [8:0] trim_word,
    output logic osc_request
);
    localparam int AW = $clog2(ALIVE_CYCLES + 1);
    localparam int OW = $clog2(OSC_INIT_CYCLES + 1);

    // ------------------------------------------------------------
    // registers and field decode
    // ------------------------------------------------------------
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic osc_ready;
    wire logic hit_c1 = bus_req.addr == `FMC_OFS_CTRL1;
    wire logic hit_c2 = bus_req.addr == `FMC_OFS_CTRL2;
    wire logic hit_tr = bus_req.addr == `FMC_OFS_TRIM;
    wire logic hit_st = bus_req.addr == `FMC_OFS_STATUS;
    wire logic [1:0] source_select = ctrl1[7:6];
    wire logic [2:0] ref_divider = ctrl1[5:3];
    wire logic ref_select_internal = ctrl1[2];
    wire logic internal_ref_enable = ctrl1[1];
    wire logic internal_ref_stop_enable = ctrl1[0];
    wire logic [1:0] bus_divider = ctrl2[7:6];
    wire logic low_power_bit = ctrl2[3];
    wire logic oscillator_request = ctrl2[2];
    wire logic external_ref_enable = ctrl2[1];
    wire logic external_ref_stop_enable = ctrl2[0];

    // ------------------------------------------------------------
    // clock input sampling: fll, internal ref, external ref
    // ------------------------------------------------------------
    wire logic [2:0] src_raw = {ext_ref_clk, int_ref_clk, fll_clk_in};
    wire logic [2:0] src_edge;
    wire logic [2:0] src_alive;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_src
            logic [2:0] sq;
            logic filt;
            logic [AW-1:0] idle_cnt;
            logic edge_q;
            wire logic agree = sq[1] == sq[2];
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    sq <= 3'h0;
                    filt <= 1'b0;
                    edge_q <= 1'b0;
                    idle_cnt <= '0;
                end else begin
                    sq <= {sq[1:0], src_raw[gi]};
                    filt <= agree ? sq[1] : filt;
                    edge_q <= agree && sq[1] && !filt;
                    if (edge_q)
                        idle_cnt <= '0;
                    else if (idle_cnt != AW'(ALIVE_CYCLES))
                        idle_cnt <= idle_cnt + 1'b1;
                end
            end
            // a source with no edge for the timeout counts as absent
            assign src_alive[gi] = idle_cnt != AW'(ALIVE_CYCLES);
            assign src_edge[gi] = edge_q;
        end
    endgenerate

    // ------------------------------------------------------------
    // reference switch
    // ------------------------------------------------------------
    logic active_ref_int;
    logic [11:0] ref_cnt;
    wire logic new_ref_edge = ref_select_internal ?
        src_edge[FMC_SRC_INT] : src_edge[FMC_SRC_EXT];
    wire logic [11:0] ref_need = `FMC_SWITCH_CYCLES << ref_divider;
    wire logic ref_pending = ref_select_internal != active_ref_int;
    wire logic ref_done = ref_pending && new_ref_edge &&
        (ref_cnt == ref_need - 12'h001);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            active_ref_int <= 1'b1;
            ref_cnt <= 12'h000;
        end else if (!ref_pending || ref_done) begin
            active_ref_int <= ref_select_internal;
            ref_cnt <= 12'h000;
        end else if (new_ref_edge) begin
            ref_cnt <= ref_cnt + 12'h001;
        end
    end

    // ------------------------------------------------------------
    // divided reference and fll frequency compare
    // ------------------------------------------------------------
    logic [7:0] refd_cnt;
    logic [11:0] fll_cnt;
    wire logic act_ref_edge = active_ref_int ?
        src_edge[FMC_SRC_INT] : src_edge[FMC_SRC_EXT];
    wire logic [7:0] ref_div_last = (8'h01 << ref_divider) - 8'h01;
    wire logic ref_tick = act_ref_edge && (refd_cnt >= ref_div_last);
    wire logic lp_bypass = low_power_bit && !debug_mode_active &&
        (source_select == `FMC_SS_INT || source_select == `FMC_SS_EXT);
    wire logic fll_on = !stop_mode && !lp_bypass;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            refd_cnt <= 8'h00;
            fll_cnt <= 12'h000;
            dco_faster <= 1'b0;
            dco_slower <= 1'b0;
            fll_enable <= 1'b1;
        end else begin
            fll_enable <= fll_on;
            if (act_ref_edge)
                refd_cnt <= ref_tick ? 8'h00 : refd_cnt + 8'h01;
            if (ref_tick) begin
                // fll is steered toward 1024 edges per divided period
                dco_faster <= fll_on && fll_cnt < `FMC_FLL_FACTOR;
                dco_slower <= fll_on && fll_cnt > `FMC_FLL_FACTOR;
                fll_cnt <= 12'h000;
            end else if (src_edge[FMC_SRC_FLL] && fll_cnt != 12'hfff) begin
                fll_cnt <= fll_cnt + 12'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // source switch
    // ------------------------------------------------------------
    fmc_state_type state;
    fmc_src_type active_src;
    fmc_src_type target_src;
    logic [11:0] sw_cnt;
    wire fmc_src_type req_src = source_select == `FMC_SS_INT ? FMC_SRC_INT :
        source_select == `FMC_SS_EXT ? FMC_SRC_EXT : FMC_SRC_FLL;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= FMC_RUN;
            active_src <= FMC_SRC_FLL;
            target_src <= FMC_SRC_FLL;
            sw_cnt <= 12'h000;
        end else begin
            case (state)
                FMC_RUN: begin
                    sw_cnt <= 12'h000;
                    target_src <= req_src;
                    if (req_src != active_src && src_alive[req_src])
                        state <= FMC_SWITCH;
                end
                FMC_SWITCH: begin
                    // an absent new clock leaves the old one in use
                    if (req_src != target_src || !src_alive[target_src]) begin
                        state <= FMC_RUN;
                    end else if (src_edge[target_src]) begin
                        sw_cnt <= sw_cnt + 12'h001;
                        if (sw_cnt == `FMC_SWITCH_CYCLES - 12'h001) begin
                            active_src <= target_src;
                            state <= FMC_RUN;
                        end
                    end
                end
                default: state <= FMC_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // bus divider and clock enables
    // ------------------------------------------------------------
    logic [2:0] bus_cnt;
    wire logic sel_edge = src_edge[active_src];
    wire logic [2:0] bus_last = (3'h1 << bus_divider) - 3'h1;
    // >= lets a smaller divider act on the very next edge
    wire logic bus_wrap = bus_cnt >= bus_last;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus_cnt <= 3'h0;
            output_clock_en <= 1'b0;
            debug_link_clock_en <= 1'b0;
            internal_ref_output_en <= 1'b0;
            external_ref_output_en <= 1'b0;
        end else begin
            if (sel_edge)
                bus_cnt <= bus_wrap ? 3'h0 : bus_cnt + 3'h1;
            output_clock_en <= !stop_mode && sel_edge && bus_wrap;
            debug_link_clock_en <= fll_on && src_edge[FMC_SRC_FLL];
            internal_ref_output_en <= src_edge[FMC_SRC_INT] &&
                internal_ref_enable &&
                (!stop_mode || internal_ref_stop_enable);
            external_ref_output_en <= src_edge[FMC_SRC_EXT] &&
                external_ref_enable &&
                (!stop_mode || external_ref_stop_enable);
        end
    end

    // ------------------------------------------------------------
    // oscillator initialization
    // ------------------------------------------------------------
    logic [OW-1:0] osc_cnt;
    wire logic ext_needed = external_ref_enable ||
        source_select == `FMC_SS_EXT ||
        (source_select == `FMC_SS_FLL && !ref_select_internal);
    wire logic osc_set = oscillator_request && ext_needed &&
        src_edge[FMC_SRC_EXT] && osc_cnt == OW'(OSC_INIT_CYCLES - 1);
    wire logic en_cleared = bus_req.wr && hit_c2 && external_ref_enable &&
        !bus_req.wdata[1];
    wire logic osc_clr = !oscillator_request || en_cleared;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            osc_cnt <= '0;
            osc_ready <= 1'b0;
        end else begin
            if (!oscillator_request)
                osc_cnt <= '0;
            else if (ext_needed && src_edge[FMC_SRC_EXT] &&
                     osc_cnt != OW'(OSC_INIT_CYCLES - 1))
                osc_cnt <= osc_cnt + 1'b1;
            // set wins over clear in the same cycle
            if (osc_set)
                osc_ready <= 1'b1;
            else if (osc_clr)
                osc_ready <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register writes, status sync and read back
    // ------------------------------------------------------------
    logic [2:0] st_sync1;
    logic [2:0] st_sync2;
    wire logic [7:0] status_rd = {3'h0, st_sync2[2], st_sync2[1:0],
        osc_ready, trim_word[0]};
    wire logic [7:0] next_rdata = hit_c1 ? ctrl1 : hit_c2 ? ctrl2 :
        hit_tr ? trim_word[8:1] : status_rd;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl1 <= `FMC_CTRL1_RST;
            ctrl2 <= `FMC_CTRL2_RST;
            trim_word <= `FMC_TRIM_RST;
            st_sync1 <= 3'h4;
            st_sync2 <= 3'h4;
            rdata <= `FMC_ZERO8;
            osc_request <= 1'b0;
        end else begin
            if (bus_req.wr && hit_c1)
                ctrl1 <= bus_req.wdata;
            else if (bus_req.wr && hit_c2)
                ctrl2 <= bus_req.wdata;
            else if (bus_req.wr && hit_tr)
                trim_word[8:1] <= bus_req.wdata;
            else if (bus_req.wr && hit_st)
                trim_word[0] <= bus_req.wdata[`FMC_ST_FINE_TRIM];
            st_sync1 <= {active_ref_int, active_src};
            st_sync2 <= st_sync1;
            rdata <= bus_req.rd ? next_rdata : `FMC_ZERO8;
            osc_request <= oscillator_request;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_status_write;
        bus_req.wr && hit_st;
    endsequence

    sequence s_ref_request;
        $changed(ref_select_internal) && ref_pending;
    endsequence

    a_ref_status_sync: assert property (
        ##2 status_rd[`FMC_ST_REF] == $past(active_ref_int, 2))
        else $error("ref status not two cycles behind active reference");
    a_ref_not_immediate: assert property (
        s_ref_request |=> active_ref_int == $past(active_ref_int))
        else $error("reference switched without waiting");
    a_mode_hold_absent: assert property (
        state == FMC_SWITCH && !src_alive[target_src]
        |=> active_src == $past(active_src) && state == FMC_RUN)
        else $error("source switched to an absent clock");
    a_fll_speed_up: assert property (
        ref_tick && fll_on && fll_cnt < `FMC_FLL_FACTOR |=> dco_faster)
        else $error("fll below target not sped up");
    a_fine_trim_write: assert property (
        s_status_write |=> trim_word[0] == $past(bus_req.wdata[0]))
        else $error("fine trim write lost");
    a_osc_set_wins: assert property (
        osc_set |=> osc_ready ##1 (osc_ready || $past(osc_clr)))
        else $error("osc ready not set after init");
    a_stop_static: assert property (
        stop_mode |=> !output_clock_en && !debug_link_clock_en)
        else $error("clock ran in stop");
    a_low_power_off: assert property (
        lp_bypass |=> !fll_enable && !debug_link_clock_en)
        else $error("fll running in low power bypass");
    a_read_latency: assert property (
        bus_req.rd && hit_c1 |=> rdata == $past(ctrl1))
        else $error("read data not one cycle later");
endmodule

`default_nettype wire

// *** src/fmc_map.svh ***
// register map, field positions, reset values and timing counts
`ifndef FMC_MAP_SVH
`define FMC_MAP_SVH

`define FMC_ADDR_W 2
`define FMC_OFS_CTRL1 2'h0
`define FMC_OFS_CTRL2 2'h1
`define FMC_OFS_TRIM 2'h2
`define FMC_OFS_STATUS 2'h3

`define FMC_CTRL1_RST 8'h04
`define FMC_CTRL2_RST 8'h40
`define FMC_TRIM_RST 9'h100
`define FMC_ZERO8 8'h00

`define FMC_SS_FLL 2'h0
`define FMC_SS_INT 2'h1
`define FMC_SS_EXT 2'h2

`define FMC_ST_REF 4
`define FMC_ST_OSC 1
`define FMC_ST_FINE_TRIM 0

`define FMC_FLL_FACTOR 12'h0400
`define FMC_SWITCH_CYCLES 12'h0002
`define FMC_ALIVE_CYCLES 16384
`define FMC_OSC_INIT_CYCLES 4096

`endif

// *** src/fmc_pkg.sv ***
// types shared by the clock mode controller
`default_nettype none
package fmc_pkg;
    typedef enum logic [1:0] {
        FMC_SRC_FLL,
        FMC_SRC_INT,
        FMC_SRC_EXT
    } fmc_src_type;

    typedef enum logic {
        FMC_RUN,
        FMC_SWITCH
    } fmc_state_type;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fmc_bus_req_type;
endpackage
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the clock mode controller
`timescale 1ns/100ps
`default_nettype none
`include "fmc_map.svh"
module tb;
// ----------------------------------------
// signals and clocks
// ----------------------------------------
logic clk = 1'b0;
logic resetn = 1'b0;
fmc_pkg::fmc_bus_req_type bus_req = '0;
logic [7:0] rdata;
logic fll_clk_in = 1'b0;
logic int_ref_clk = 1'b0;
logic ext_ref_clk = 1'b0;
logic debug_mode_active = 1'b0;
logic stop_mode = 1'b0;
logic output_clock_en, debug_link_clock_en, fll_enable;
logic internal_ref_output_en, external_ref_output_en;
logic dco_faster, dco_slower, osc_request;
logic [8:0] trim_word;
logic ext_run = 1'b1;
int fc = 0, ic = 0, ec = 0;
int bad_count = 0, total_checks = 0;
int n_out, n_dbg, n_int, n_ext;
logic [7:0] st;

// short alive window so an absent source is seen quickly
fmc_controller #(.ALIVE_CYCLES(64), .OSC_INIT_CYCLES(4)) fmc_controller_i (
    .clk(clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
    .fll_clk_in(fll_clk_in), .int_ref_clk(int_ref_clk),
    .ext_ref_clk(ext_ref_clk), .debug_mode_active(debug_mode_active),
    .stop_mode(stop_mode), .output_clock_en(output_clock_en),
    .debug_link_clock_en(debug_link_clock_en),
    .internal_ref_output_en(internal_ref_output_en),
    .external_ref_output_en(external_ref_output_en),
    .fll_enable(fll_enable), .dco_faster(dco_faster),
    .dco_slower(dco_slower), .trim_word(trim_word),
    .osc_request(osc_request));

initial begin
    forever #2.5 clk = ~clk;
end

// periods: fll 10, internal 20, external 14 cycles; slow enough to sample
always @(posedge clk) begin
    fc <= (fc == 4) ? 0 : fc + 1;
    ic <= (ic == 9) ? 0 : ic + 1;
    ec <= (ec == 6) ? 0 : ec + 1;
    if (fc == 4) fll_clk_in <= ~fll_clk_in;
    if (ic == 9) int_ref_clk <= ~int_ref_clk;
    if (ec == 6 && ext_run) ext_ref_clk <= ~ext_ref_clk;
end
// ----------------------------------------
// shared tasks
// ----------------------------------------
task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    total_checks++;
    if (g !== e) begin
        bad_count++;
        $display("BAD %s expected %h seen %h", nm, e, g);
    end
endtask
// rates are counted, so one edge of slack for window alignment
task automatic near(input string nm, input int e, input int g);
    total_checks++;
    if (g < e - 1 || g > e + 1) begin
        bad_count++;
        $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
endtask
task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    @(posedge clk);
endtask
task automatic rd(input logic [1:0] a, output logic [7:0] v);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    v = rdata;
    @(posedge clk);
endtask
task automatic count(input int n);
    n_out = 0; n_dbg = 0; n_int = 0; n_ext = 0;
    repeat (n) begin
        @(posedge clk);
        #1;
        n_out += output_clock_en;
        n_dbg += debug_link_clock_en;
        n_int += internal_ref_output_en;
        n_ext += external_ref_output_en;
    end
    @(posedge clk);
endtask
task automatic poll(input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    for (int i = 0; i < 200; i++) begin
        rd(`FMC_OFS_STATUS, v);
        if ((v & m) === e) return;
    end
    bad_count++;
    $display("BAD status poll expected %h seen %h", e, v & m);
    print_verdict();
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic t_reset();
    rd(`FMC_OFS_CTRL1, st);
    chk("ctrl1", `FMC_CTRL1_RST, st);
    rd(`FMC_OFS_CTRL2, st);
    chk("ctrl2", `FMC_CTRL2_RST, st);
    rd(`FMC_OFS_STATUS, st);
    chk("status", 8'h10, st);
    #1;
    chk("rdata idle", 9'h000, rdata);
    chk("trim", `FMC_TRIM_RST, trim_word);
    chk("fll on", 9'h001, fll_enable);
    @(posedge clk);
    $display("test reset done");
endtask
task automatic t_trim();
    wr(`FMC_OFS_STATUS, 8'h01);
    rd(`FMC_OFS_STATUS, st);
    chk("status reserved", 8'h11, st);
    chk("fine trim set", 9'h101, trim_word);
    wr(`FMC_OFS_TRIM, 8'h3C);
    chk("trim word", 9'h079, trim_word);
    wr(`FMC_OFS_STATUS, 8'h00);
    chk("fine trim clear", 9'h078, trim_word);
    $display("test trim done");
endtask
task automatic t_busdiv();
    for (int k = 0; k < 4; k++) begin
        wr(`FMC_OFS_CTRL2, {k[1:0], 6'h00});
        count(640);
        near("bus divider", 64 >> k, n_out);
    end
    near("link rate", 64, n_dbg);
    chk("dco faster", 9'h001, dco_faster);
    chk("dco slower", 9'h000, dco_slower);
    wr(`FMC_OFS_CTRL2, 8'h40);
    $display("test bus divider done");
endtask
task automatic t_modes();
    logic [7:0] c1 [6] = '{8'h04, 8'h00, 8'h44, 8'h44, 8'h80, 8'h80};
    logic lp [6] = '{0, 0, 0, 1, 0, 1};
    logic dbg [6] = '{0, 0, 1, 0, 0, 0};
    logic fo [6] = '{1, 1, 1, 0, 1, 0};
    int eo [6] = '{28, 28, 14, 14, 20, 20};
    logic [7:0] e;
    logic [7:0] prev;
    prev = 8'h10;
    for (int i = 0; i < 6; i++) begin
        debug_mode_active <= dbg[i];
        wr(`FMC_OFS_CTRL2, {4'h4, lp[i], 3'h0});
        wr(`FMC_OFS_CTRL1, c1[i]);
        e = {3'h0, c1[i][2], c1[i][7:6], 2'h0};
        rd(`FMC_OFS_STATUS, st);
        chk("status held", prev, st & 8'h1C);
        poll(8'h1C, e);
        chk("fll enable", fo[i], fll_enable);
        count(560);
        near("source rate", eo[i], n_out);
        near("link rate", fo[i] ? 56 : 0, n_dbg);
        prev = e;
    end
    debug_mode_active <= 1'b0;
    wr(`FMC_OFS_CTRL2, 8'h40);
    wr(`FMC_OFS_CTRL1, 8'h04);
    poll(8'h1C, 8'h10);
    $display("test modes done");
endtask
task automatic t_absent();
    ext_run <= 1'b0;
    repeat (200) @(posedge clk);
    wr(`FMC_OFS_CTRL1, 8'h84);
    repeat (300) @(posedge clk);
    rd(`FMC_OFS_STATUS, st);
    chk("old source kept", 8'h10, st & 8'h1C);
    ext_run <= 1'b1;
    poll(8'h1C, 8'h18);
    wr(`FMC_OFS_CTRL1, 8'h04);
    poll(8'h1C, 8'h10);
    $display("test absent source done");
endtask
task automatic t_osc();
    wr(`FMC_OFS_CTRL2, 8'h46);
    // the copy is launched on the edge the write task returns on
    @(posedge clk);
    chk("osc request", 9'h001, osc_request);
    poll(8'h02, 8'h02);
    wr(`FMC_OFS_CTRL2, 8'h44);
    poll(8'h02, 8'h00);
    wr(`FMC_OFS_CTRL2, 8'h46);
    poll(8'h02, 8'h02);
    wr(`FMC_OFS_CTRL2, 8'h42);
    poll(8'h02, 8'h00);
    wr(`FMC_OFS_CTRL2, 8'h40);
    $display("test oscillator done");
endtask
task automatic t_stop();
    wr(`FMC_OFS_CTRL1, 8'h07);
    wr(`FMC_OFS_CTRL2, 8'h42);
    stop_mode <= 1'b1;
    count(280);
    near("stop output", 0, n_out);
    near("stop link", 0, n_dbg);
    near("stop internal", 14, n_int);
    near("stop external", 0, n_ext);
    wr(`FMC_OFS_CTRL2, 8'h43);
    wr(`FMC_OFS_CTRL1, 8'h06);
    count(280);
    near("stop external on", 20, n_ext);
    near("stop internal off", 0, n_int);
    stop_mode <= 1'b0;
    wr(`FMC_OFS_CTRL1, 8'h04);
    wr(`FMC_OFS_CTRL2, 8'h40);
    $display("test stop done");
endtask
// ----------------------------------------
// main sequence
// ----------------------------------------
initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_trim();
    t_busdiv();
    t_modes();
    t_absent();
    t_osc();
    t_stop();
    print_verdict();
end
endmodule
`default_nettype wire
